// ==== logic/frt_pkg.sv ====
// constants shared by the fault ride-through supervisor
package frt_pkg;
    localparam int VW    = 12;           // voltage sample width
    localparam int TW    = 16;           // elapsed-time width, ms
    localparam int CW    = 16;           // event counter width
    localparam int NPROT = 15;           // suppressible trip groups
    localparam int NVOLT = 5;
    localparam int NTIME = 6;
    // timing
    localparam int CLK_PERIOD_NS  = 100;
    localparam int TICK_PERIOD_NS = 1000000;   // 1 ms time base
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_VOLT  = 8'h04;  // five voltage words
    localparam logic [7:0] OFF_TIME  = 8'h18;  // six time words
    localparam logic [7:0] OFF_STAT  = 8'h30;
    localparam logic [7:0] OFF_COUNT = 8'h34;
    // control bits
    localparam int CTRL_EN    = 0;
    localparam int CTRL_MAINS = 1;
    localparam int CTRL_GENS  = 2;
    localparam int CTRL_CLR   = 3;            // write 1: clear counter
    // voltage word indexes
    localparam int V_RET  = 0;
    localparam int V_CLR  = 1;
    localparam int V_REC1 = 2;
    localparam int V_REC2 = 3;
    localparam int V_REC3 = 4;
    // time word indexes
    localparam int T_CLR   = 0;
    localparam int T_REC1  = 1;
    localparam int T_REC2  = 2;
    localparam int T_REC3  = 3;
    localparam int T_REC4  = 4;
    localparam int T_TRANS = 5;
    // reset values
    localparam logic [VW-1:0] VOLT_RST = 12'h000;
    localparam logic [TW-1:0] TIME_RST = 16'h0000;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_EVENT = 3'b010,
        ST_HELD  = 3'b100
    } frt_mode_type;
endpackage : frt_pkg

// ==== logic/frt_supervisor.sv ====
// fault ride-through supervisor with apb register slave
`timescale 1ns/1ps
`default_nettype none
// Function
// - operate when mains, generator or both paralleled
// - curve from voltage levels at successive intervals
// - dip below level three raises event alarm
// - above curve, low-voltage trip is suppressed
// - below curve, low-voltage alarm after transient delay
// - event ends after interval four and recovery
// - no recovery at interval four keeps alarm
// - failed recovery stops all suppression until fresh event
// - suppress listed protection trips during event while above curve
// - warnings are never suppressed
// - each activation increments the event counter, which saturates at all ones
// - event counter readable over register bus
// - maintenance reset clears the event counter
module frt_supervisor #(
    parameter int TICK_CYCLES = frt_pkg::TICK_CYCLES,
    parameter int NPROT       = frt_pkg::NPROT
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [frt_pkg::VW-1:0]   volt_l1,
    input  wire logic [frt_pkg::VW-1:0]   volt_l2,
    input  wire logic [frt_pkg::VW-1:0]   volt_l3,
    input  wire logic                     volt_valid,
    input  wire logic                     mains_parallel_pin,
    input  wire logic                     gens_parallel_pin,
    input  wire logic [NPROT-1:0]         prot_trip_req,
    output logic      [NPROT-1:0]         prot_trip_out,
    input  wire logic                     low_voltage_trip_req,
    output logic                          low_voltage_trip_out,
    input  wire logic                     low_voltage_warning_req,
    output logic                          low_voltage_warning_out,
    output logic                          ride_through_event_alarm,
    output logic                          gen_low_voltage_alarm
);
    localparam int VW  = frt_pkg::VW;
    localparam int TW  = frt_pkg::TW;
    localparam int CW  = frt_pkg::CW;
    localparam int TDW = $clog2(TICK_CYCLES);

    typedef struct packed {
        frt_pkg::frt_mode_type            st;
        logic                             ack;
        logic [31:0]                      rdata;
        logic                             err;
        logic                             en;
        logic                             mains_sel;
        logic                             gens_sel;
        logic [frt_pkg::NVOLT-1:0][VW-1:0] vcfg;
        logic [frt_pkg::NTIME-1:0][TW-1:0] tcfg;
        logic [1:0]                       sy1;
        logic [1:0]                       sy2;
        logic [TDW-1:0]                   tdiv;
        logic [TW-1:0]                    elapsed;
        logic [TW-1:0]                    trans;
        logic                             below;
        logic                             lv;
        logic [CW-1:0]                    count;
        logic [NPROT-1:0]                 trip;
        logic                             lvtrip;
        logic                             lvwarn;
    } frt_state_type;

    frt_state_type r;
    frt_state_type n;
    logic          tick;
    logic          active;
    logic          suppress;
    logic          cnt_clr;
    logic          start;
    logic [VW-1:0] vmin;
    logic [VW-1:0] limit;
    logic [7:0]    vidx;
    logic [7:0]    tidx;

    // stepped limit curve: level rises at each configured interval
    function automatic logic [VW-1:0] curve(input frt_state_type s);
        if (s.elapsed < s.tcfg[frt_pkg::T_CLR])
            return s.vcfg[frt_pkg::V_RET];
        else if (s.elapsed < s.tcfg[frt_pkg::T_REC1])
            return s.vcfg[frt_pkg::V_CLR];
        else if (s.elapsed < s.tcfg[frt_pkg::T_REC2])
            return s.vcfg[frt_pkg::V_REC1];
        else if (s.elapsed < s.tcfg[frt_pkg::T_REC3])
            return s.vcfg[frt_pkg::V_REC2];
        else
            return s.vcfg[frt_pkg::V_REC3];
    endfunction : curve

    // next-state logic
    always_comb
    begin
        n = r;
        tick = (r.tdiv == TDW'(TICK_CYCLES - 1));
        n.tdiv = tick ? '0 : r.tdiv + 1'b1;
        // lowest of the three phases
        vmin = volt_l1;
        if (volt_l2 < vmin)
            vmin = volt_l2;
        if (volt_l3 < vmin)
            vmin = volt_l3;
        limit = curve(r);
        active = r.en && ((r.mains_sel && r.sy2[0]) || (r.gens_sel && r.sy2[1]));
        // pins: second stage only reads the first
        n.sy1 = {gens_parallel_pin, mains_parallel_pin};
        n.sy2 = r.sy1;

        // apb: one wait state so read data comes from a flop
        vidx = (paddr - frt_pkg::OFF_VOLT) >> 2;
        tidx = (paddr - frt_pkg::OFF_TIME) >> 2;
        cnt_clr = 1'b0;
        n.ack = 1'b0;
        n.err = 1'b0;
        if (psel && penable && !r.ack)
        begin
            n.ack = 1'b1;
            n.rdata = '0;
            if (paddr == frt_pkg::OFF_CTRL)
                n.rdata[frt_pkg::CTRL_GENS:0] = {r.gens_sel, r.mains_sel, r.en};
            else if (paddr[1:0] == 2'b00 && vidx < 8'(frt_pkg::NVOLT) && paddr >= frt_pkg::OFF_VOLT)
                n.rdata[VW-1:0] = r.vcfg[vidx[2:0]];
            else if (paddr[1:0] == 2'b00 && tidx < 8'(frt_pkg::NTIME) && paddr >= frt_pkg::OFF_TIME)
                n.rdata[TW-1:0] = r.tcfg[tidx[2:0]];
            else if (paddr == frt_pkg::OFF_STAT)
                n.rdata[6:0] = {r.sy2, r.below, r.lv, r.st};
            else if (paddr == frt_pkg::OFF_COUNT)
                n.rdata[CW-1:0] = r.count;
            else
                n.err = 1'b1;                       // unmapped: error, reads zero
        end
        // writes land on the edge that sees pready high
        if (psel && penable && r.ack && pwrite && !r.err)
        begin
            if (paddr == frt_pkg::OFF_CTRL)
            begin
                n.en        = pwdata[frt_pkg::CTRL_EN];
                n.mains_sel = pwdata[frt_pkg::CTRL_MAINS];
                n.gens_sel  = pwdata[frt_pkg::CTRL_GENS];
                cnt_clr     = pwdata[frt_pkg::CTRL_CLR];
            end
            else if (paddr >= frt_pkg::OFF_VOLT && vidx < 8'(frt_pkg::NVOLT))
                n.vcfg[vidx[2:0]] = pwdata[VW-1:0];
            else if (paddr >= frt_pkg::OFF_TIME && tidx < 8'(frt_pkg::NTIME))
                n.tcfg[tidx[2:0]] = pwdata[TW-1:0];
        end
        if (cnt_clr)
            n.count = '0;

        // ride-through sequence
        start = 1'b0;
        if (tick && r.elapsed != '1)
            n.elapsed = r.elapsed + 1'b1;
        case (r.st)
            frt_pkg::ST_IDLE:
            begin
                if (active && volt_valid && vmin < r.vcfg[frt_pkg::V_REC3])
                begin
                    start = 1'b1;
                    n.st = frt_pkg::ST_EVENT;
                    n.elapsed = '0;
                    n.trans = '0;
                    n.below = 1'b0;
                    // increment after any clear, so neither is lost
                    if (n.count != '1)
                        n.count = n.count + 1'b1;
                end
            end
            frt_pkg::ST_EVENT:
            begin
                if (volt_valid)
                    n.below = (vmin < limit);
                if (!r.below)
                    n.trans = '0;
                else if (tick && r.trans != '1)
                    n.trans = r.trans + 1'b1;
                if (r.below && r.trans >= r.tcfg[frt_pkg::T_TRANS])
                    n.lv = 1'b1;
                if (volt_valid && r.elapsed >= r.tcfg[frt_pkg::T_REC4])
                begin
                    if (vmin > r.vcfg[frt_pkg::V_REC3])
                        n.st = frt_pkg::ST_IDLE;
                    else
                        n.st = frt_pkg::ST_HELD;
                    n.below = 1'b0;
                end
            end
            frt_pkg::ST_HELD:
            begin
                // alarm held, nothing suppressed until the voltage recovers
                if (volt_valid && vmin > r.vcfg[frt_pkg::V_REC3])
                    n.st = frt_pkg::ST_IDLE;
            end
            default:
            begin
                n.st = frt_pkg::ST_IDLE;
            end
        endcase
        if (!active && r.st != frt_pkg::ST_IDLE)
            n.st = frt_pkg::ST_IDLE;
        if (n.st == frt_pkg::ST_IDLE)
        begin
            n.lv = 1'b0;
            n.below = 1'b0;
        end

        // gated protection outputs, registered
        suppress = (r.st == frt_pkg::ST_EVENT) && !r.below;
        n.trip   = suppress ? '0 : prot_trip_req;
        n.lvtrip = low_voltage_trip_req && !suppress;
        n.lvwarn = low_voltage_warning_req;
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r      <= '0;
            r.st   <= frt_pkg::ST_IDLE;
            r.vcfg <= {frt_pkg::NVOLT{frt_pkg::VOLT_RST}};
            r.tcfg <= {frt_pkg::NTIME{frt_pkg::TIME_RST}};
        end
        else
            r <= n;
    end

    assign prdata   = r.rdata;
    assign pready   = r.ack;
    assign pslverr  = r.ack && r.err;
    assign prot_trip_out           = r.trip;
    assign low_voltage_trip_out    = r.lvtrip;
    assign low_voltage_warning_out = r.lvwarn;
    assign ride_through_event_alarm = (r.st != frt_pkg::ST_IDLE);
    assign gen_low_voltage_alarm   = r.lv;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_start;
        start |=> ride_through_event_alarm && r.st == frt_pkg::ST_EVENT;
    endproperty
    a_start: assert property (p_start) else $error("event not raised on dip");

    property p_lvsupp;
        suppress && low_voltage_trip_req |=> !low_voltage_trip_out;
    endproperty
    a_lvsupp: assert property (p_lvsupp) else $error("low-voltage trip leaked");

    property p_protsupp;
        suppress |=> prot_trip_out == '0;
    endproperty
    a_protsupp: assert property (p_protsupp) else $error("protection trip leaked");

    property p_warn;
        1'b1 |=> low_voltage_warning_out == $past(low_voltage_warning_req);
    endproperty
    a_warn: assert property (p_warn) else $error("warning was gated");

    property p_count;
        start && !cnt_clr && r.count != '1 |=> r.count == $past(r.count) + 1'b1;
    endproperty
    a_count: assert property (p_count) else $error("counter missed event");

    property p_hold;
        r.st == frt_pkg::ST_EVENT && r.elapsed < r.tcfg[frt_pkg::T_REC4] && active
            |=> r.st == frt_pkg::ST_EVENT;
    endproperty
    a_hold: assert property (p_hold) else $error("event ended early");

    property p_fail;
        r.st == frt_pkg::ST_EVENT && active && volt_valid && r.elapsed >= r.tcfg[frt_pkg::T_REC4]
            && vmin <= r.vcfg[frt_pkg::V_REC3] |=> ride_through_event_alarm ##0 r.st == frt_pkg::ST_HELD;
    endproperty
    a_fail: assert property (p_fail) else $error("alarm not held");

    property p_nosupp;
        r.st == frt_pkg::ST_HELD |=> prot_trip_out == $past(prot_trip_req);
    endproperty
    a_nosupp: assert property (p_nosupp) else $error("suppression after fail");

    property p_clr;
        cnt_clr && !start |=> r.count == '0;
    endproperty
    a_clr: assert property (p_clr) else $error("counter not cleared");

    property p_lv;
        r.st == frt_pkg::ST_EVENT && n.st == frt_pkg::ST_EVENT && r.below
            && r.trans >= r.tcfg[frt_pkg::T_TRANS] |=> gen_low_voltage_alarm;
    endproperty
    a_lv: assert property (p_lv) else $error("low-voltage alarm late");

    c_recover: cover property (r.st == frt_pkg::ST_EVENT ##1 r.st == frt_pkg::ST_IDLE);
    c_held:    cover property (r.st == frt_pkg::ST_EVENT ##1 r.st == frt_pkg::ST_HELD);
    c_lv:      cover property ($rose(gen_low_voltage_alarm));
endmodule : frt_supervisor
`default_nettype wire

// ==== testbench/frt_meas_model.sv ====
// behavioural model of the phase voltage measurement feeding the supervisor
`timescale 1ns/1ps
`default_nettype none
module frt_meas_model #(
    parameter int PERIOD = 5
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic [frt_pkg::VW-1:0] level,
    output logic      [frt_pkg::VW-1:0] volt_l1,
    output logic      [frt_pkg::VW-1:0] volt_l2,
    output logic      [frt_pkg::VW-1:0] volt_l3,
    output logic                        volt_valid
);
    int         cnt;
    logic [2:0] low;
    // one update pulse every PERIOD clocks; the lowest phase rotates so the minimum search is exercised
    // between pulses the lines show inverted junk so a stale sample cannot pass unnoticed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt        <= 0;
            low        <= 3'h1;
            volt_valid <= 1'b0;
            volt_l1    <= 12'h000;
            volt_l2    <= 12'h000;
            volt_l3    <= 12'h000;
        end
        else
        begin
            cnt        <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            volt_valid <= (cnt == PERIOD - 1);
            if (cnt == PERIOD - 1)
                low <= {low[1:0], low[2]};
            volt_l1    <= (cnt == PERIOD - 1) ? (low[0] ? level : level + 12'h014) : ~(level + 12'h014);
            volt_l2    <= (cnt == PERIOD - 1) ? (low[1] ? level : level + 12'h028) : ~level;
            volt_l3    <= (cnt == PERIOD - 1) ? (low[2] ? level : level + 12'h014) : ~(level + 12'h028);
        end
    end
endmodule : frt_meas_model
`default_nettype wire

// ==== testbench/tb_frt_supervisor.sv ====
// self-checking testbench of the ride-through supervisor over apb
`timescale 1ns/1ps
`default_nettype none
module tb_frt_supervisor;
    localparam int TICKS = 10;              // 1 ms = 10 clocks keeps the run short
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, volt_valid;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [11:0] volt_l1, volt_l2, volt_l3, level;
    logic        mains_pin, gens_pin, lv_req, lv_out, warn_req, warn_out, event_alarm, lv_alarm, err;
    logic [14:0] trip_req, trip_out;
    int          n_errors, check_count, cyc, i;

    frt_supervisor #(.TICK_CYCLES(TICKS), .NPROT(15)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .volt_l1(volt_l1), .volt_l2(volt_l2), .volt_l3(volt_l3), .volt_valid(volt_valid),
        .mains_parallel_pin(mains_pin), .gens_parallel_pin(gens_pin),
        .prot_trip_req(trip_req), .prot_trip_out(trip_out),
        .low_voltage_trip_req(lv_req), .low_voltage_trip_out(lv_out),
        .low_voltage_warning_req(warn_req), .low_voltage_warning_out(warn_out),
        .ride_through_event_alarm(event_alarm), .gen_low_voltage_alarm(lv_alarm));

    frt_meas_model #(.PERIOD(5)) meas (
        .pclk(pclk), .presetn(presetn), .level(level), .volt_l1(volt_l1),
        .volt_l2(volt_l2), .volt_l3(volt_l3), .volt_valid(volt_valid));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("errors %0d, comparisons %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no own limit: only the bench ceiling ends a stuck wait
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        q       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // bounded wait for the event alarm to reach a level
    task automatic wait_alarm(input logic v, input int lim);
        for (i = 0; i < lim && event_alarm !== v; i++)
            @(posedge pclk);
        check(event_alarm, v);
    endtask : wait_alarm

    // hang guard: ceiling well above the at most 713 clocks the sequence needs
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            end_sim();
        end
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, n_errors, check_count} = '0;
        {mains_pin, gens_pin, lv_req, warn_req, trip_req} = {4'b1011, 15'h7FFF};
        level   = 12'h258;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, frt_pkg::OFF_STAT, 0);
        check(q, 32'h0000_0021);
        apb(0, 8'h38, 0);
        check(q, 32'h0);
        check(err, 1'b1);
        for (int k = 0; k < 5; k++)                    // levels 100..500: rising curve
            apb(1, frt_pkg::OFF_VOLT + 8'(4 * k), 32'd100 * (k + 1));
        for (int k = 0; k < 6; k++)                    // times 2,4,6,8,10 ms, transient 3 ms
            apb(1, frt_pkg::OFF_TIME + 8'(4 * k), (k == 5) ? 32'd3 : 32'd2 * (k + 1));
        apb(0, frt_pkg::OFF_TIME + 8'h14, 0);
        check(q, 32'h3);
        // generators selected but that pin is low: a dip must be ignored
        apb(1, frt_pkg::OFF_CTRL, 32'h5);
        level <= 12'h1C2;
        repeat (30) @(posedge pclk);
        check(event_alarm, 1'b0);
        // mains selected: a dip above the curve starts a suppressing event
        apb(1, frt_pkg::OFF_CTRL, 32'h3);
        wait_alarm(1'b1, 40);
        repeat (3) @(posedge pclk);
        check({trip_out, lv_out}, 16'h0);
        check(warn_out, 1'b1);
        level <= 12'h258;
        repeat (40) @(posedge pclk);
        check(event_alarm, 1'b1);
        wait_alarm(1'b0, 200);
        repeat (3) @(posedge pclk);
        check({trip_out, lv_out}, 16'hFFFF);
        // dip below the curve, then no recovery by interval four
        level <= 12'h032;
        wait_alarm(1'b1, 40);
        repeat (60) @(posedge pclk);
        check(lv_alarm, 1'b1);
        check({trip_out, lv_out}, 16'hFFFF);
        repeat (100) @(posedge pclk);
        apb(0, frt_pkg::OFF_STAT, 0);
        check(q[2:0], 3'b100);
        check({event_alarm, trip_out}, 16'hFFFF);
        level <= 12'h258;
        wait_alarm(1'b0, 50);
        check(lv_alarm, 1'b0);
        // a fresh dip is a third activation
        level <= 12'h1C2;
        wait_alarm(1'b1, 40);
        repeat (3) @(posedge pclk);
        check(trip_out, 15'h0);
        apb(0, frt_pkg::OFF_COUNT, 0);
        check(q, 32'h3);
        apb(1, frt_pkg::OFF_CTRL, 32'hB);
        apb(0, frt_pkg::OFF_COUNT, 0);
        check(q, 32'h0);
        apb(0, frt_pkg::OFF_CTRL, 0);
        check(q, 32'h3);
        end_sim();
    end
endmodule : tb_frt_supervisor
`default_nettype wire
